// ===== design/cpu_control_reg_reset_init.sv
// Control register bank of the memory side and bus interface, with its reset state
//
// How it works
// - reset loads memory-box control low bits with 0x100, write buffer on.
// - cycle counter disabled at reset; count and control otherwise undefined.
// - reset: board cache off, forced hit off, chip enable on RAM writes.
// - reset clears phys-addr disable and bad-tag-parity; bad-data-parity undefined.
// - serial transmit register drives a pin; firmware initialises it.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cpu_control_reg_reset_init #(
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory-box controls
   output logic writeBufferEn,
   output logic machineCheckEn,
   output logic corrReadIntEn,
   output logic streamBufferEn,
   output logic dataCacheEn,
   output logic forcedHitEn,
   // Bus-interface controls
   output logic boardCacheEn,
   output logic boardCacheForcedHit,
   output logic chipEnableOnWrite,
   output logic parityMode,
   output logic [3:0] boardCacheRdSpeed,
   output logic [3:0] boardCacheWrSpeed,
   output logic [3:0] boardCacheWeCtl,
   output logic [3:0] boardCacheSize,
   output logic [3:0] boardCachePhysAddrDisable,
   output logic badTagParityCtl,
   output logic badDataParityCtl,
   // Translation buffer
   output logic largePageSel,
   output logic tbInvalidateAll,
   // Cycle counter and serial pin
   output logic cycleCountEn,
   output logic serialTxPin
);
   logic [11:0] memBox_reg;
   logic busDef_reg;
   logic [3:0] paDis_reg;
   logic badTcp_reg;
   logic bcFhit_reg;
   logic ceWr_reg;
   logic ccEn_reg;
   logic tbInvalDone_reg;
   logic tbSizeSet_reg;
   logic serSet_reg;
   logic bcProg_reg;
   logic invalPulse_reg;
   logic [31:0] busUndef;
   logic [31:0] cntCtlUndef;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] cntNext;
   logic [31:0] tbCtlUndef;
   logic [31:0] serUndef;
   logic [31:0] rdNext;
   logic wrAcc;
   logic rdAcc;
   logic mapped;
   logic wrBus;
   logic wrCc;
   logic wrCnt;
   logic wrTb;
   logic wrSer;
   logic cntLoad;
   logic selMemBox;
   logic selBus;
   logic selCc;
   logic selCnt;
   logic selTb;
   logic selSer;
   logic selStatus;
   logic selInval;
   logic wrMemBox;
   logic wrInval;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wrAcc = psel && penable && pwrite && clkEn;
   assign rdAcc = psel && !penable && !pwrite;
   // One-hot select; an address outside the map raises the bus error and touches nothing
   always_comb begin
      selMemBox = 1'b0;
      selBus = 1'b0;
      selCc = 1'b0;
      selCnt = 1'b0;
      selTb = 1'b0;
      selSer = 1'b0;
      selStatus = 1'b0;
      selInval = 1'b0;
      case (paddr)
         cpu_ctl_pkg::MEM_BOX_CTL_OFF: selMemBox = 1'b1;
         cpu_ctl_pkg::BUS_IF_CTL_OFF: selBus = 1'b1;
         cpu_ctl_pkg::CYC_CNT_CTL_OFF: selCc = 1'b1;
         cpu_ctl_pkg::CYC_CNT_OFF: selCnt = 1'b1;
         cpu_ctl_pkg::TRANSLATION_BUFFER_CONTROL_OFF: selTb = 1'b1;
         cpu_ctl_pkg::SER_XMIT_OFF: selSer = 1'b1;
         cpu_ctl_pkg::STATUS_OFF: selStatus = 1'b1;
         cpu_ctl_pkg::TB_INVAL_OFF: selInval = 1'b1;
         default: selInval = 1'b0;
      endcase
   end
   assign mapped = selMemBox || selBus || selCc || selCnt || selTb || selSer || selStatus
      || selInval;
   assign pslverr = psel && penable && !mapped;
   assign wrMemBox = wrAcc && selMemBox;
   assign wrBus = wrAcc && selBus;
   assign wrCc = wrAcc && selCc;
   assign wrCnt = wrAcc && selCnt;
   assign wrTb = wrAcc && selTb;
   assign wrSer = wrAcc && selSer;
   assign wrInval = wrAcc && selInval;

   // Memory-box control
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         memBox_reg <= cpu_ctl_pkg::MEM_BOX_RESET;
      end else if (wrMemBox) begin
         memBox_reg <= pwdata[cpu_ctl_pkg::MEM_BOX_W-1:0];
      end
   end

   // Defined bus-interface bits
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busDef_reg <= cpu_ctl_pkg::BI_BC_EN_RESET;
         bcFhit_reg <= cpu_ctl_pkg::BI_FHIT_RESET;
         ceWr_reg <= cpu_ctl_pkg::BI_CE_WR_RESET;
         paDis_reg <= cpu_ctl_pkg::BI_PA_DIS_RESET;
         badTcp_reg <= cpu_ctl_pkg::BI_BAD_TAG_PARITY_CTL_RESET;
      end else if (wrBus) begin
         busDef_reg <= pwdata[cpu_ctl_pkg::BI_BC_EN];
         bcFhit_reg <= pwdata[cpu_ctl_pkg::BI_FHIT];
         ceWr_reg <= pwdata[cpu_ctl_pkg::BI_CE_WR];
         paDis_reg <= pwdata[cpu_ctl_pkg::BI_PA_DIS_LSB +: cpu_ctl_pkg::BI_PA_DIS_W];
         badTcp_reg <= pwdata[cpu_ctl_pkg::BI_BAD_TAG_PARITY_CTL];
      end
   end

   // Undefined parts: parity, speeds, write enable, size, bad data parity
   undef_reg #(.WIDTH(32)) busUndefReg (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .load(wrBus),
      .loadData(pwdata),
      .value(busUndef)
   );

   // Counter control word beyond the enable stays undefined
   undef_reg #(.WIDTH(32)) ccCtlReg (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .load(wrCc),
      .loadData(pwdata),
      .value(cntCtlUndef)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ccEn_reg <= cpu_ctl_pkg::CC_EN_RESET;
      end else if (wrCc) begin
         ccEn_reg <= pwdata[cpu_ctl_pkg::CC_EN];
      end
   end

   // Counter value has no reset; it counts only once enabled
   assign cntLoad = wrCnt || (ccEn_reg && clkEn);
   assign cntNext = wrCnt ? pwdata[CNT_W-1:0] : cnt + CNT_W'(1);
   undef_reg #(.WIDTH(CNT_W)) cntReg (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .load(cntLoad),
      .loadData(cntNext),
      .value(cnt)
   );

   // Page size select, unknown until written
   undef_reg #(.WIDTH(32)) tbCtlReg (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .load(wrTb),
      .loadData(pwdata),
      .value(tbCtlUndef)
   );

   // Serial transmit bit drives the pin directly
   undef_reg #(.WIDTH(32)) serReg (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .load(wrSer),
      .loadData(pwdata),
      .value(serUndef)
   );

   // Firmware progress flags, readable so software can check its bring-up order
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tbInvalDone_reg <= 1'b0;
         tbSizeSet_reg <= 1'b0;
         serSet_reg <= 1'b0;
         bcProg_reg <= 1'b0;
      end else if (clkEn) begin
         if (wrInval) begin
            tbInvalDone_reg <= 1'b1;
         end
         if (wrTb) begin
            tbSizeSet_reg <= 1'b1;
         end
         if (wrSer) begin
            serSet_reg <= 1'b1;
         end
         if (wrBus) begin
            bcProg_reg <= 1'b1;
         end
      end
   end

   // Invalidate-all strobe, one cycle per write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         invalPulse_reg <= 1'b0;
      end else if (clkEn) begin
         invalPulse_reg <= wrInval;
      end
   end

   // Read mux, latched in setup so data come from a flip-flop
   always_comb begin
      rdNext = 32'h00000000;
      case (paddr)
         cpu_ctl_pkg::MEM_BOX_CTL_OFF: rdNext = {20'h00000, memBox_reg};
         cpu_ctl_pkg::BUS_IF_CTL_OFF: begin
            rdNext = busUndef;
            rdNext[cpu_ctl_pkg::BI_BC_EN] = busDef_reg;
            rdNext[cpu_ctl_pkg::BI_FHIT] = bcFhit_reg;
            rdNext[cpu_ctl_pkg::BI_CE_WR] = ceWr_reg;
            rdNext[cpu_ctl_pkg::BI_PA_DIS_LSB +: cpu_ctl_pkg::BI_PA_DIS_W] = paDis_reg;
            rdNext[cpu_ctl_pkg::BI_BAD_TAG_PARITY_CTL] = badTcp_reg;
         end
         cpu_ctl_pkg::CYC_CNT_CTL_OFF: begin
            rdNext = cntCtlUndef;
            rdNext[cpu_ctl_pkg::CC_EN] = ccEn_reg;
         end
         cpu_ctl_pkg::CYC_CNT_OFF: rdNext = 32'(cnt);
         cpu_ctl_pkg::TRANSLATION_BUFFER_CONTROL_OFF: rdNext = tbCtlUndef;
         cpu_ctl_pkg::SER_XMIT_OFF: rdNext = serUndef;
         cpu_ctl_pkg::STATUS_OFF: begin
            rdNext[cpu_ctl_pkg::ST_TB_INVAL_DONE] = tbInvalDone_reg;
            rdNext[cpu_ctl_pkg::ST_TB_SIZE_SET] = tbSizeSet_reg;
            rdNext[cpu_ctl_pkg::ST_SER_SET] = serSet_reg;
            rdNext[cpu_ctl_pkg::ST_BC_PROG] = bcProg_reg;
         end
         default: rdNext = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (clkEn && rdAcc) begin
         prdata <= rdNext;
      end
   end

   // Outputs
   assign writeBufferEn = memBox_reg[cpu_ctl_pkg::MB_WB_EN];
   assign machineCheckEn = memBox_reg[cpu_ctl_pkg::MB_MCHK_EN];
   assign corrReadIntEn = memBox_reg[cpu_ctl_pkg::MB_CRD_EN];
   assign streamBufferEn = memBox_reg[cpu_ctl_pkg::MB_ISTREAM_EN];
   assign dataCacheEn = memBox_reg[cpu_ctl_pkg::MB_DCACHE_EN];
   assign forcedHitEn = memBox_reg[cpu_ctl_pkg::MB_FHIT];
   // Board cache timing is the firmware's job before enabling; hardware only passes it on
   assign boardCacheEn = busDef_reg;
   assign boardCacheForcedHit = bcFhit_reg;
   assign chipEnableOnWrite = ceWr_reg;
   assign parityMode = busUndef[cpu_ctl_pkg::BI_PARITY];
   assign boardCacheRdSpeed = busUndef[cpu_ctl_pkg::BI_RD_SPD_LSB +: 4];
   assign boardCacheWrSpeed = busUndef[cpu_ctl_pkg::BI_WR_SPD_LSB +: 4];
   assign boardCacheWeCtl = busUndef[cpu_ctl_pkg::BI_WE_CTL_LSB +: 4];
   assign boardCacheSize = busUndef[cpu_ctl_pkg::BI_SIZE_LSB +: 4];
   assign boardCachePhysAddrDisable = paDis_reg;
   assign badTagParityCtl = badTcp_reg;
   assign badDataParityCtl = busUndef[cpu_ctl_pkg::BI_BAD_DATA_PARITY_CTL];
   assign largePageSel = tbCtlUndef[0];
   assign tbInvalidateAll = invalPulse_reg;
   assign cycleCountEn = ccEn_reg;
   assign serialTxPin = serUndef[0];
endmodule : cpu_control_reg_reset_init

// ===== design/cpu_ctl_pkg.sv
// Package with register offsets, field layouts and reset values of the control register bank
package cpu_ctl_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] MEM_BOX_CTL_OFF = 12'h000;
   localparam logic [11:0] BUS_IF_CTL_OFF = 12'h004;
   localparam logic [11:0] CYC_CNT_CTL_OFF = 12'h008;
   localparam logic [11:0] CYC_CNT_OFF = 12'h00C;
   localparam logic [11:0] TRANSLATION_BUFFER_CONTROL_OFF = 12'h010;
   localparam logic [11:0] SER_XMIT_OFF = 12'h014;
   localparam logic [11:0] STATUS_OFF = 12'h018;
   localparam logic [11:0] TB_INVAL_OFF = 12'h01C;

   // Memory-box control: low twelve bits, reset value
   localparam int MEM_BOX_W = 12;
   localparam logic [11:0] MEM_BOX_RESET = 12'h100;
   localparam int MB_WB_EN = 8;
   localparam int MB_MCHK_EN = 0;
   localparam int MB_CRD_EN = 1;
   localparam int MB_ISTREAM_EN = 2;
   localparam int MB_DCACHE_EN = 3;
   localparam int MB_FHIT = 4;

   // Bus-interface control field positions
   localparam int BI_BC_EN = 0;
   localparam int BI_PARITY = 1;
   localparam int BI_CE_WR = 2;
   localparam int BI_FHIT = 3;
   localparam int BI_RD_SPD_LSB = 4;
   localparam int BI_WR_SPD_LSB = 8;
   localparam int BI_WE_CTL_LSB = 12;
   localparam int BI_SIZE_LSB = 16;
   localparam int BI_PA_DIS_LSB = 20;
   localparam int BI_PA_DIS_W = 4;
   localparam int BI_BAD_TAG_PARITY_CTL = 24;
   localparam int BI_BAD_DATA_PARITY_CTL = 25;

   // Defined part of bus-interface control after reset
   localparam logic BI_BC_EN_RESET = 1'b0;
   localparam logic BI_FHIT_RESET = 1'b0;
   localparam logic BI_CE_WR_RESET = 1'b1;
   localparam logic [3:0] BI_PA_DIS_RESET = 4'h0;
   localparam logic BI_BAD_TAG_PARITY_CTL_RESET = 1'b0;

   // Cycle counter control bits
   localparam int CC_EN = 0;
   localparam logic CC_EN_RESET = 1'b0;

   // Status bits
   localparam int ST_TB_INVAL_DONE = 0;
   localparam int ST_TB_SIZE_SET = 1;
   localparam int ST_SER_SET = 2;
   localparam int ST_BC_PROG = 3;
endpackage : cpu_ctl_pkg

// ===== design/undef_reg.sv
// Word register with no reset, for state that starts unknown
`timescale 1ns/1ps
module undef_reg #(
   parameter int WIDTH = 32
) (
   // Clock
   input wire logic core_clk,
   input wire logic clkEn,
   // Load
   input wire logic load,
   input wire logic [WIDTH-1:0] loadData,
   // Contents
   output logic [WIDTH-1:0] value
);
   // No reset: contents are unknown until software writes
   always_ff @(posedge core_clk) begin
      if (clkEn && load) begin
         value <= loadData;
      end
   end
endmodule : undef_reg

// ===== verification/cpu_control_reg_reset_init_properties.sv
// Checker of reset state and register effects of the control bank
`timescale 1ns/1ps
module cpu_control_reg_reset_init_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // APB requests
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Memory-box controls
   input wire logic writeBufferEn,
   input wire logic machineCheckEn,
   input wire logic corrReadIntEn,
   input wire logic streamBufferEn,
   input wire logic dataCacheEn,
   input wire logic forcedHitEn,
   // Bus-interface, translation, counter, serial
   input wire logic boardCacheEn,
   input wire logic boardCacheForcedHit,
   input wire logic chipEnableOnWrite,
   input wire logic [3:0] boardCachePhysAddrDisable,
   input wire logic badTagParityCtl,
   input wire logic tbInvalidateAll,
   input wire logic cycleCountEn,
   input wire logic serialTxPin
);
   default clocking @(posedge core_clk); endclocking
   // Writes taken only with the bank clock enabled
   wire logic wrAcc = psel && penable && pwrite && clkEn;
   a_mem_box_reset: assert property (rst [*2] |->
      writeBufferEn && !machineCheckEn && !corrReadIntEn) else $error("memory box reset wrong");
   a_mem_box_off: assert property ($past(rst) && rst |->
      !streamBufferEn && !dataCacheEn && !forcedHitEn) else $error("memory box units not off");
   a_cycle_off: assert property (rst [*2] |-> !cycleCountEn)
      else $error("cycle counter enabled in reset");
   a_bus_reset: assert property (rst [*2] |->
      !boardCacheEn && !boardCacheForcedHit && chipEnableOnWrite) else $error("bus reset wrong");
   a_pa_dis_clear: assert property (rst [*2] |->
      boardCachePhysAddrDisable == 4'h0 && !badTagParityCtl) else $error("bus fields not cleared");
   a_serial_pin: assert property (disable iff (rst)
      wrAcc && paddr == cpu_ctl_pkg::SER_XMIT_OFF |=> serialTxPin == $past(pwdata[0]))
      else $error("serial pin not following register");
   a_mem_box_write: assert property (disable iff (rst)
      wrAcc && paddr == cpu_ctl_pkg::MEM_BOX_CTL_OFF |=>
      writeBufferEn == $past(pwdata[8]) && forcedHitEn == $past(pwdata[4]))
      else $error("memory box write not applied");
   a_inval_pulse: assert property (disable iff (rst)
      wrAcc && paddr == cpu_ctl_pkg::TB_INVAL_OFF |=> tbInvalidateAll ##1 !tbInvalidateAll)
      else $error("invalidate pulse wrong");
   a_freeze_hold: assert property (disable iff (rst)
      !clkEn |=> $stable(writeBufferEn) && $stable(boardCacheEn) && $stable(cycleCountEn)
      && $stable(tbInvalidateAll)) else $error("state moved while clock enable low");
endmodule : cpu_control_reg_reset_init_properties

bind cpu_control_reg_reset_init cpu_control_reg_reset_init_properties chk_u (
   .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .writeBufferEn(writeBufferEn),
   .machineCheckEn(machineCheckEn), .corrReadIntEn(corrReadIntEn),
   .streamBufferEn(streamBufferEn), .dataCacheEn(dataCacheEn), .forcedHitEn(forcedHitEn),
   .boardCacheEn(boardCacheEn), .boardCacheForcedHit(boardCacheForcedHit),
   .chipEnableOnWrite(chipEnableOnWrite), .boardCachePhysAddrDisable(boardCachePhysAddrDisable),
   .badTagParityCtl(badTagParityCtl), .tbInvalidateAll(tbInvalidateAll),
   .cycleCountEn(cycleCountEn), .serialTxPin(serialTxPin));

// ===== verification/test_cpu_control_reg_reset_init.sv
// Self-checking bench of the control register bank
`timescale 1ns/1ps
module test_cpu_control_reg_reset_init;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, d, c0;
   logic writeBufferEn, machineCheckEn, corrReadIntEn, streamBufferEn, dataCacheEn, forcedHitEn;
   logic boardCacheEn, boardCacheForcedHit, chipEnableOnWrite, parityMode, badTagParityCtl;
   logic badDataParityCtl, largePageSel, tbInvalidateAll, cycleCountEn, serialTxPin;
   logic [3:0] boardCacheRdSpeed, boardCacheWrSpeed, boardCacheWeCtl, boardCacheSize, paDis;
   logic [31:0] seed = 32'h0000B8B2;
   int err_count = 0, compares = 0;
   cpu_control_reg_reset_init dut_u (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .writeBufferEn(writeBufferEn),
      .machineCheckEn(machineCheckEn), .corrReadIntEn(corrReadIntEn),
      .streamBufferEn(streamBufferEn), .dataCacheEn(dataCacheEn), .forcedHitEn(forcedHitEn),
      .boardCacheEn(boardCacheEn), .boardCacheForcedHit(boardCacheForcedHit),
      .chipEnableOnWrite(chipEnableOnWrite), .parityMode(parityMode),
      .boardCacheRdSpeed(boardCacheRdSpeed), .boardCacheWrSpeed(boardCacheWrSpeed),
      .boardCacheWeCtl(boardCacheWeCtl), .boardCacheSize(boardCacheSize),
      .boardCachePhysAddrDisable(paDis), .badTagParityCtl(badTagParityCtl),
      .badDataParityCtl(badDataParityCtl), .largePageSel(largePageSel),
      .tbInvalidateAll(tbInvalidateAll), .cycleCountEn(cycleCountEn), .serialTxPin(serialTxPin));
   always #5 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [31:0] mbExp(input logic [31:0] w);
      return {26'h0, w[8], w[0], w[1], w[2], w[3], w[4]};
   endfunction : mbExp
   function automatic logic [31:0] mbSeen();
      return {26'h0, writeBufferEn, machineCheckEn, corrReadIntEn, streamBufferEn, dataCacheEn,
         forcedHitEn};
   endfunction : mbSeen
   function automatic logic [31:0] biSeen();
      return {6'h0, badDataParityCtl, badTagParityCtl, paDis, boardCacheSize, boardCacheWeCtl,
         boardCacheWrSpeed, boardCacheRdSpeed, boardCacheForcedHit, chipEnableOnWrite,
         parityMode, boardCacheEn};
   endfunction : biSeen
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Idle cycle after each transfer keeps every signal to one change per edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
         output logic [31:0] r, output logic er);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      chk("memBoxRst", mbSeen(), mbExp(32'h00000100));
      chk("busRst", biSeen() & 32'h01F0000D, 32'h00000004);
      chk("cycleEnRst", cycleCountEn, 32'h0);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, cpu_ctl_pkg::MEM_BOX_CTL_OFF, 32'h0, q, e);
      chk("memBoxRd", q, 32'h00000100);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 32'h00000FFF : rnd() & 32'h00000FFF;
         apb(1'b1, cpu_ctl_pkg::MEM_BOX_CTL_OFF, d, q, e);
         chk("memBox", mbSeen(), mbExp(d));
         apb(1'b0, cpu_ctl_pkg::MEM_BOX_CTL_OFF, 32'h0, q, e);
         chk("memBoxBack", q, d);
      end
      // Timing and size first, enable last
      d = (rnd() & 32'h03FFFFFF) | 32'h03100003;
      apb(1'b1, cpu_ctl_pkg::BUS_IF_CTL_OFF, d & 32'hFFFFFFFE, q, e);
      apb(1'b1, cpu_ctl_pkg::BUS_IF_CTL_OFF, d, q, e);
      chk("busCtl", biSeen(), d & 32'h03FFFFFF);
      apb(1'b1, cpu_ctl_pkg::CYC_CNT_CTL_OFF, 32'h1, q, e);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("busKeep", biSeen(), (d & 32'h020FFFF2) | 32'h4);
      chk("memBoxRst2", mbSeen(), mbExp(32'h00000100));
      chk("cycleEnRst2", cycleCountEn, 32'h0);
      apb(1'b0, cpu_ctl_pkg::STATUS_OFF, 32'h0, q, e);
      chk("statusRst", q, 32'h0);
      c0 = rnd();
      apb(1'b1, cpu_ctl_pkg::CYC_CNT_OFF, c0, q, e);
      apb(1'b0, cpu_ctl_pkg::CYC_CNT_OFF, 32'h0, q, e);
      chk("cycleHeld", q, c0);
      apb(1'b1, cpu_ctl_pkg::CYC_CNT_CTL_OFF, 32'h1, q, e);
      chk("cycleEn", cycleCountEn, 32'h1);
      apb(1'b0, cpu_ctl_pkg::CYC_CNT_OFF, 32'h0, c0, e);
      apb(1'b0, cpu_ctl_pkg::CYC_CNT_OFF, 32'h0, q, e);
      chk("cycleStep", q - c0, 32'h3);
      apb(1'b1, cpu_ctl_pkg::TB_INVAL_OFF, 32'h1, q, e);
      for (int v = 0; v < 2; v++) begin
         apb(1'b1, cpu_ctl_pkg::TRANSLATION_BUFFER_CONTROL_OFF, v, q, e);
         apb(1'b1, cpu_ctl_pkg::SER_XMIT_OFF, v, q, e);
         chk("largePage", largePageSel, v);
         chk("serialPin", serialTxPin, v);
      end
      apb(1'b0, cpu_ctl_pkg::STATUS_OFF, 32'h0, q, e);
      chk("status", q, 32'h00000007);
      apb(1'b1, 12'h020, rnd(), q, e);
      chk("unmapWrErr", e, 32'h1);
      apb(1'b0, 12'h020, 32'h0, q, e);
      chk("unmapRdErr", e, 32'h1);
      chk("unmapRd", q, 32'h0);
      chk("ready", pready, 32'h1);
      // Frozen bank must ignore a write
      apb(1'b0, cpu_ctl_pkg::MEM_BOX_CTL_OFF, 32'h0, q, e);
      clkEn <= 1'b0;
      apb(1'b1, cpu_ctl_pkg::MEM_BOX_CTL_OFF, ~q, d, e);
      clkEn <= 1'b1;
      apb(1'b0, cpu_ctl_pkg::MEM_BOX_CTL_OFF, 32'h0, d, e);
      chk("frozenWr", d, q);
      // Return-stack priming is firmware work beyond this bank
      end_of_test();
   end
endmodule : test_cpu_control_reg_reset_init
